//--- rtl/cipg_pkg.sv
// constants and carrier types of the core interrupt priority gate
// Overview of operation
// - local lines rank by descending index: line three first, line zero last.
// - external ranks below all local lines, above software; timer ranks lowest.
// - nothing reaches the core unless the global interrupt enable bit is set.
// - each interrupt type also needs its own enable bit before delivery.
// - external interrupt is delivered only while its enable bit is set.
// - software interrupt is delivered only while its enable bit is set.
// - timer interrupt is delivered only while its enable bit is set.
// - enable bits 16 to 19 gate local lines zero to three in order.
package cipg_pkg;

  // register byte offsets
  localparam logic [7:0]  CIPG_GLOBAL_OFS   = 8'h00;
  localparam logic [7:0]  CIPG_ENABLE_OFS   = 8'h04;
  localparam logic [7:0]  CIPG_PENDING_OFS  = 8'h08;
  localparam logic [7:0]  CIPG_GRANT_OFS    = 8'h0C;
  localparam logic [7:0]  CIPG_EVT_STAT_OFS = 8'h10;
  localparam logic [7:0]  CIPG_EVT_MASK_OFS = 8'h14;

  // field positions
  localparam int unsigned CIPG_GLOBAL_POS   = 3;
  localparam int unsigned CIPG_SW_POS       = 3;
  localparam int unsigned CIPG_TMR_POS      = 7;
  localparam int unsigned CIPG_EXT_POS      = 11;
  localparam int unsigned CIPG_LOCAL_POS    = 16;
  localparam int unsigned CIPG_GRANT_VLD    = 31;

  // reset values and implemented bits
  localparam logic [31:0] CIPG_GLOBAL_RST   = 32'h0000_0000;
  localparam logic [31:0] CIPG_ENABLE_RST   = 32'h0000_0000;
  localparam logic [31:0] CIPG_EVT_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] CIPG_SRC_BITS     = 32'h000F_0888;
  localparam logic [31:0] CIPG_GLOBAL_BITS  = 32'h0000_0008;

  // bus responses
  localparam logic [1:0]  CIPG_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  CIPG_RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic [3:0] local_line;
    logic       ext;
    logic       sw;
    logic       tmr;
  } cipg_src_type;

  typedef struct packed {
    logic       req;
    logic [4:0] cause;
  } cipg_trap_type;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } cipg_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cipg_axi_rsp_type;

endpackage

//--- rtl/cipg_gate.sv
// core interrupt priority gate with its axi4-lite register slave
`timescale 1ns/1ps
module cipg_gate
  import cipg_pkg::*;
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  // register bus
  input  wire cipg_axi_req_type axi_in,
  output cipg_axi_rsp_type      axi_out,
  // interrupt sources, same clock domain
  input  wire cipg_src_type     src_in,
  // core trap entry
  output cipg_trap_type         trap_out,
  // event interrupt
  output logic                  irq_out
);

  // highest source in the order is tested last, so later tests override earlier ones
  function automatic logic [4:0] cipg_pick(input logic [31:0] act);
    logic [4:0] c;
    c = 5'h00;
    if (act[CIPG_TMR_POS])        c = 5'(CIPG_TMR_POS);
    if (act[CIPG_SW_POS])         c = 5'(CIPG_SW_POS);
    if (act[CIPG_EXT_POS])        c = 5'(CIPG_EXT_POS);
    if (act[CIPG_LOCAL_POS])      c = 5'(CIPG_LOCAL_POS);
    if (act[CIPG_LOCAL_POS + 1])  c = 5'(CIPG_LOCAL_POS + 1);
    if (act[CIPG_LOCAL_POS + 2])  c = 5'(CIPG_LOCAL_POS + 2);
    if (act[CIPG_LOCAL_POS + 3])  c = 5'(CIPG_LOCAL_POS + 3);
    return c;
  endfunction

  function automatic logic [31:0] cipg_strb(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  logic [31:0]   global_r;
  logic [31:0]   global_nxt;
  logic [31:0]   enable_r;
  logic [31:0]   enable_nxt;
  logic [31:0]   evt_stat_r;
  logic [31:0]   evt_stat_nxt;
  logic [31:0]   evt_mask_r;
  logic [31:0]   evt_mask_nxt;
  cipg_trap_type trap_r;
  cipg_trap_type trap_nxt;
  logic          aw_hold_r;
  logic          aw_hold_nxt;
  logic [7:0]    aw_addr_r;
  logic [7:0]    aw_addr_nxt;
  logic          w_hold_r;
  logic          w_hold_nxt;
  logic [31:0]   w_data_r;
  logic [31:0]   w_data_nxt;
  logic [3:0]    w_strb_r;
  logic [3:0]    w_strb_nxt;
  logic          bvalid_r;
  logic          bvalid_nxt;
  logic [1:0]    bresp_r;
  logic [1:0]    bresp_nxt;
  logic          rvalid_r;
  logic          rvalid_nxt;
  logic [31:0]   rdata_r;
  logic [31:0]   rdata_nxt;
  logic [1:0]    rresp_r;
  logic [1:0]    rresp_nxt;

  logic [31:0]   pend_vec;
  logic [31:0]   eligible;
  logic          glob_on;
  logic          aw_take;
  logic          w_take;
  logic          ar_take;
  logic          wr_go;
  logic [31:0]   evt_set;
  logic [31:0]   evt_clr;

  // raw sources laid out like the enable register
  always_comb
  begin
    pend_vec                          = 32'h0000_0000;
    pend_vec[CIPG_SW_POS]             = src_in.sw;
    pend_vec[CIPG_TMR_POS]            = src_in.tmr;
    pend_vec[CIPG_EXT_POS]            = src_in.ext;
    pend_vec[CIPG_LOCAL_POS +: 4]     = src_in.local_line;
  end

  assign glob_on  = global_r[CIPG_GLOBAL_POS];
  // global gate and per-type enable, bit for bit
  assign eligible = glob_on ? (pend_vec & enable_r & CIPG_SRC_BITS) : 32'h0000_0000;

  assign aw_take  = axi_in.awvalid && !aw_hold_r && !bvalid_r;
  assign w_take   = axi_in.wvalid && !w_hold_r && !bvalid_r;
  assign ar_take  = axi_in.arvalid && !rvalid_r;
  assign wr_go    = aw_hold_r && w_hold_r;

  always_comb
  begin
    axi_out         = '0;
    axi_out.awready = !aw_hold_r && !bvalid_r;
    axi_out.wready  = !w_hold_r && !bvalid_r;
    axi_out.bvalid  = bvalid_r;
    axi_out.bresp   = bresp_r;
    axi_out.arready = !rvalid_r;
    axi_out.rvalid  = rvalid_r;
    axi_out.rdata   = rdata_r;
    axi_out.rresp   = rresp_r;
  end

  always_comb
  begin
    // one source per cycle; lower ones wait behind it
    trap_nxt.req   = |eligible;
    trap_nxt.cause = cipg_pick(eligible);
    // a new grant, or a change of grant, is an event
    evt_set = 32'h0000_0000;
    if (trap_nxt.req && (!trap_r.req || trap_r.cause != trap_nxt.cause))
      evt_set[trap_nxt.cause] = 1'b1;
    evt_clr = 32'h0000_0000;
    if (ar_take && axi_in.araddr == CIPG_EVT_STAT_OFS)
      evt_clr = 32'hFFFF_FFFF;
    // set beats the clearing read in the same cycle
    evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_set;

    global_nxt   = global_r;
    enable_nxt   = enable_r;
    evt_mask_nxt = evt_mask_r;
    aw_hold_nxt  = aw_hold_r | aw_take;
    aw_addr_nxt  = aw_take ? axi_in.awaddr : aw_addr_r;
    w_hold_nxt   = w_hold_r | w_take;
    w_data_nxt   = w_take ? axi_in.wdata : w_data_r;
    w_strb_nxt   = w_take ? axi_in.wstrb : w_strb_r;
    bvalid_nxt   = bvalid_r && !axi_in.bready;
    bresp_nxt    = bresp_r;
    if (wr_go)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = CIPG_RESP_OKAY;
      case (aw_addr_r)
        CIPG_GLOBAL_OFS:
          global_nxt = cipg_strb(global_r, w_data_r, w_strb_r) & CIPG_GLOBAL_BITS;
        CIPG_ENABLE_OFS:
          enable_nxt = cipg_strb(enable_r, w_data_r, w_strb_r) & CIPG_SRC_BITS;
        CIPG_EVT_MASK_OFS:
          evt_mask_nxt = cipg_strb(evt_mask_r, w_data_r, w_strb_r) & CIPG_SRC_BITS;
        CIPG_PENDING_OFS, CIPG_GRANT_OFS, CIPG_EVT_STAT_OFS:
          bresp_nxt = CIPG_RESP_OKAY;
        default:
          bresp_nxt = CIPG_RESP_SLVERR;
      endcase
    end

    rvalid_nxt = rvalid_r && !axi_in.rready;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (ar_take)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = CIPG_RESP_OKAY;
      case (axi_in.araddr)
        CIPG_GLOBAL_OFS:   rdata_nxt = global_r;
        CIPG_ENABLE_OFS:   rdata_nxt = enable_r;
        CIPG_PENDING_OFS:  rdata_nxt = pend_vec;
        CIPG_GRANT_OFS:    rdata_nxt = {trap_r.req, 26'h0, trap_r.cause};
        CIPG_EVT_STAT_OFS: rdata_nxt = evt_stat_r;
        CIPG_EVT_MASK_OFS: rdata_nxt = evt_mask_r;
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = CIPG_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      global_r   <= CIPG_GLOBAL_RST;
      enable_r   <= CIPG_ENABLE_RST;
      evt_stat_r <= 32'h0000_0000;
      evt_mask_r <= CIPG_EVT_MASK_RST;
      trap_r     <= '0;
      aw_hold_r  <= 1'b0;
      aw_addr_r  <= 8'h00;
      w_hold_r   <= 1'b0;
      w_data_r   <= 32'h0000_0000;
      w_strb_r   <= 4'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= CIPG_RESP_OKAY;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= CIPG_RESP_OKAY;
    end
    else
    begin
      global_r   <= global_nxt;
      enable_r   <= enable_nxt;
      evt_stat_r <= evt_stat_nxt;
      evt_mask_r <= evt_mask_nxt;
      trap_r     <= trap_nxt;
      aw_hold_r  <= aw_hold_nxt;
      aw_addr_r  <= aw_addr_nxt;
      w_hold_r   <= w_hold_nxt;
      w_data_r   <= w_data_nxt;
      w_strb_r   <= w_strb_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  // level output: any unmasked sticky event
  assign irq_out  = |(evt_stat_r & evt_mask_r);
  assign trap_out = trap_r;

  // helper views for the checks below
  logic [31:0] elig_no_tmr;
  assign elig_no_tmr = eligible & ~(32'h1 << CIPG_TMR_POS);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_l3_ready;
    src_in.local_line[3] && enable_r[CIPG_LOCAL_POS + 3] && glob_on;
  endsequence

  sequence s_l2_alone;
    src_in.local_line[2] && enable_r[CIPG_LOCAL_POS + 2] && glob_on
      && !(src_in.local_line[3] && enable_r[CIPG_LOCAL_POS + 3]);
  endsequence

  sequence s_l0_only;
    glob_on && enable_r[CIPG_LOCAL_POS] && src_in.local_line == 4'h1;
  endsequence

  // address and data taken on one edge
  sequence s_write_taken;
    aw_take && w_take;
  endsequence

  a_line_three_top: assert property (s_l3_ready |=> trap_out.req
    && trap_out.cause == 5'(CIPG_LOCAL_POS + 3))
    else $error("local line three not granted first");
  a_line_two_next: assert property (s_l2_alone |=> trap_out.cause == 5'(CIPG_LOCAL_POS + 2))
    else $error("local line two not granted");
  a_ext_under_local: assert property (eligible[CIPG_EXT_POS]
    && |eligible[CIPG_LOCAL_POS +: 4] |=> trap_out.cause != 5'(CIPG_EXT_POS))
    else $error("external beat a local line");
  a_timer_last_rank: assert property (trap_out.req && trap_out.cause == 5'(CIPG_TMR_POS)
    |-> $past(elig_no_tmr) == 32'h0000_0000)
    else $error("timer granted over a higher source");
  a_global_gate_off: assert property (!glob_on |=> !trap_out.req)
    else $error("request without global enable");
  // whole vector taken back one cycle, then indexed by the cause now shown
  a_type_enable_on: assert property (trap_out.req
    |-> |($past(enable_r) & (32'h1 << trap_out.cause)))
    else $error("request for a disabled type");
  a_ext_enable_bit: assert property (!enable_r[CIPG_EXT_POS]
    |=> !(trap_out.req && trap_out.cause == 5'(CIPG_EXT_POS)))
    else $error("external delivered while disabled");
  a_sw_enable_bit: assert property (!enable_r[CIPG_SW_POS]
    |=> !(trap_out.req && trap_out.cause == 5'(CIPG_SW_POS)))
    else $error("software delivered while disabled");
  a_tmr_enable_bit: assert property (!enable_r[CIPG_TMR_POS]
    |=> !(trap_out.req && trap_out.cause == 5'(CIPG_TMR_POS)))
    else $error("timer delivered while disabled");
  a_line_zero_map: assert property ((s_l0_only and !(|eligible[CIPG_EXT_POS:0]))
    |=> trap_out.req && trap_out.cause == 5'(CIPG_LOCAL_POS))
    else $error("local line zero not on enable bit 16");
  a_single_grant: assert property (|eligible |=> trap_out.req
    && |($past(eligible) & (32'h1 << trap_out.cause))
    && $past(cipg_pick(eligible)) == trap_out.cause)
    else $error("grant is not the top eligible source");
  a_event_sticky: assert property (trap_nxt.req && !trap_r.req
    |=> evt_stat_r[$past(trap_nxt.cause)])
    else $error("grant event lost");
  // a clearing read keeps only what is set on that same edge
  a_event_clear_read: assert property (ar_take && axi_in.araddr == CIPG_EVT_STAT_OFS
    |=> evt_stat_r == $past(evt_set))
    else $error("status read left stale events");
  // fixed answer latency of the slave
  a_write_answer: assert property (s_write_taken |=> ##1 axi_out.bvalid)
    else $error("write response not raised");
  a_read_answer: assert property (ar_take |=> axi_out.rvalid)
    else $error("read data not raised");

endmodule

//--- test/cipg_core_model.sv
// core trap entry model facing the gate
`timescale 1ns/1ps
module cipg_core_model
  import cipg_pkg::*;
(
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          srst_in,
  // trap request from the gate
  input  wire cipg_trap_type trap_in,
  // observation
  output logic [4:0]         last_cause_out,
  output logic               bad_out
);
  logic [4:0] cause_r;
  logic [4:0] cause_nxt;
  logic       bad_r;
  logic       bad_nxt;

  // sticky, so a one-cycle glitch is not lost
  always_comb
  begin
    cause_nxt = trap_in.req ? trap_in.cause : cause_r;
    bad_nxt   = bad_r;
    if (!trap_in.req && trap_in.cause != 5'h00)
      bad_nxt = 1'b1;
    if (trap_in.req && !(trap_in.cause inside {5'h03, 5'h07, 5'h0B, [5'h10:5'h13]}))
      bad_nxt = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      cause_r <= 5'h00;
      bad_r   <= 1'b0;
    end
    else
    begin
      cause_r <= cause_nxt;
      bad_r   <= bad_nxt;
    end
  end

  assign last_cause_out = cause_r;
  assign bad_out        = bad_r;
endmodule

//--- test/core_interrupt_priority_gate_test.sv
// self-checking bench of the core interrupt priority gate
`timescale 1ns/1ps
module core_interrupt_priority_gate_test;
  import cipg_pkg::*;
  typedef struct packed {
    logic [6:0]  src;
    logic [31:0] en;
    logic        glb;
    logic [5:0]  exp;
  } cipg_row_type;

  logic             clk_in;
  logic             srst_in;
  cipg_axi_req_type axi;
  cipg_axi_rsp_type axi_out;
  cipg_src_type     src;
  cipg_trap_type    trap;
  logic             irq;
  logic [4:0]       last_cause;
  logic             bad;
  logic [31:0]      rdat;
  logic [1:0]       rsp;
  int               n_mismatch = 0;
  int               n_compared = 0;
  int               cyc = 0;
  cipg_row_type     rows [16];

  cipg_gate i_dut (.clk_in(clk_in), .srst_in(srst_in), .axi_in(axi), .axi_out(axi_out),
                   .src_in(src), .trap_out(trap), .irq_out(irq));
  cipg_core_model i_core (.clk_in(clk_in), .srst_in(srst_in), .trap_in(trap),
                          .last_cause_out(last_cause), .bad_out(bad));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // called just after a rising edge; handshakes judged at rising edges, payload held until taken
  // no wait count here, only the bench timeout ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic tb;
    axi.awvalid <= 1'b1;
    axi.awaddr  <= a;
    axi.wvalid  <= 1'b1;
    axi.wdata   <= d;
    tb = 1'b0;
    while (!tb)
    begin
      @(posedge clk_in);
      if (axi.awvalid && axi_out.awready)
        axi.awvalid <= 1'b0;
      if (axi.wvalid && axi_out.wready)
        axi.wvalid <= 1'b0;
      tb  = axi_out.bvalid;
      rsp = axi_out.bresp;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic tv;
    axi.arvalid <= 1'b1;
    axi.araddr  <= a;
    tv = 1'b0;
    while (!tv)
    begin
      @(posedge clk_in);
      if (axi.arvalid && axi_out.arready)
        axi.arvalid <= 1'b0;
      tv   = axi_out.rvalid;
      rdat = axi_out.rdata;
      rsp  = axi_out.rresp;
    end
  endtask

  // trap settles one edge after the sources; three edges leave margin
  task automatic put_src(input logic [6:0] v);
    src <= cipg_src_type'(v);
    repeat (3) @(posedge clk_in);
  endtask

  // run is a few hundred cycles; this only cuts a hang
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial
  begin
    srst_in = 1'b1;
    src = '0;
    axi = '0;
    axi.wstrb = 4'hF;
    axi.bready = 1'b1;
    axi.rready = 1'b1;
    rows = '{'{7'h7F, 32'h000F0888, 1'h1, 6'h33}, '{7'h3F, 32'h000F0888, 1'h1, 6'h32},
             '{7'h1F, 32'h000F0888, 1'h1, 6'h31}, '{7'h0F, 32'h000F0888, 1'h1, 6'h30},
             '{7'h07, 32'h000F0888, 1'h1, 6'h2B}, '{7'h03, 32'h000F0888, 1'h1, 6'h23},
             '{7'h01, 32'h000F0888, 1'h1, 6'h27}, '{7'h7F, 32'h000F0888, 1'h0, 6'h00},
             '{7'h07, 32'h00000088, 1'h1, 6'h23}, '{7'h02, 32'h00000880, 1'h1, 6'h00},
             '{7'h01, 32'h00000808, 1'h1, 6'h00}, '{7'h48, 32'h00010000, 1'h1, 6'h30},
             '{7'h38, 32'h00080000, 1'h1, 6'h00}, '{7'h7F, 32'h00020000, 1'h1, 6'h31},
             '{7'h0F, 32'h00010000, 1'h1, 6'h30}, '{7'h7F, 32'h00000080, 1'h1, 6'h27}};
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    foreach (rows[i])
    begin
      wr(CIPG_GLOBAL_OFS, {28'h0, rows[i].glb, 3'h0});
      wr(CIPG_ENABLE_OFS, rows[i].en);
      put_src(rows[i].src);
      chk({26'h0, trap}, {26'h0, rows[i].exp});
      rd(CIPG_GRANT_OFS);
      chk(rdat, {rows[i].exp[5], 26'h0, rows[i].exp[4:0]});
    end
    chk({27'h0, last_cause}, 32'h7);
    rd(CIPG_PENDING_OFS);
    chk(rdat, CIPG_SRC_BITS);
    rd(8'h18);
    chk(rdat, 32'h0);
    chk({30'h0, rsp}, {30'h0, CIPG_RESP_SLVERR});
    wr(8'h18, 32'hFFFF_FFFF);
    chk({30'h0, rsp}, {30'h0, CIPG_RESP_SLVERR});
    wr(CIPG_PENDING_OFS, 32'hFFFF_FFFF);
    chk({30'h0, rsp}, {30'h0, CIPG_RESP_OKAY});
    wr(CIPG_ENABLE_OFS, CIPG_SRC_BITS);
    put_src(7'h00);
    rd(CIPG_EVT_STAT_OFS);
    wr(CIPG_EVT_MASK_OFS, 32'h0000_0080);
    put_src(7'h01);
    chk({31'h0, irq}, 32'h1);
    rd(CIPG_EVT_STAT_OFS);
    chk(rdat, 32'h0000_0080);
    chk({31'h0, irq}, 32'h0);
    put_src(7'h00);
    put_src(7'h02);
    chk({31'h0, irq}, 32'h0);
    rd(CIPG_EVT_STAT_OFS);
    chk(rdat, 32'h0000_0008);
    chk({31'h0, bad}, 32'h0);
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(CIPG_GLOBAL_OFS);
    chk(rdat, CIPG_GLOBAL_RST);
    rd(CIPG_ENABLE_OFS);
    chk(rdat, CIPG_ENABLE_RST);
    rd(CIPG_EVT_MASK_OFS);
    chk(rdat, CIPG_EVT_MASK_RST);
    chk({26'h0, trap}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    tally_and_finish();
  end
endmodule
